// >>> verilog/branch_bit_core.sv
// Bit manipulation and branch execution core with stack and addressing.
// Assumes asynchronous-read memories answering the registered addresses
// in the same cycle; code port returns two consecutive bytes.
//
// What this block does
// - Carry ops 1B/1cyc; bit ops 2B/2cyc
// - Carry and accumulator jumps: 2B, 2/3 cycles
// - Bit test jumps 3B 3/4; clear variant
// - Page call 2B/3cyc; long call 3B/4cyc
// - Both returns one byte, five cycles
// - Page/long/short/indexed jumps: 3/4/3/3 cycles
// - Compare jumps 3B; 3/4, indirect 4/5
// - Decrement jumps: register 2/3, direct 3/4
// - NOP and spare opcode: one cycle
// - Relative targets: signed offset plus next address
// - Page targets replace low eleven address bits
// - Long targets carry full sixteen bits
// - Direct below 0x80 RAM, above is SFR
// - Code above last usable address is refused
// - Program store only writable with enable bit
// - Indirect above 0x7F reaches upper RAM
// - Four register banks chosen by status bits
// - Indirect address from bank register 0/1
// - Bit RAM 0x20-0x2F as bits 0x00-0x7F
// - Push increments pointer, then writes
// - Stack pointer resets to 0x07
// - SFRs ending 0/8 are bit addressable
`default_nettype none

module branch_bit_core #(
	parameter logic [15:0] CODE_LIMIT = cpu_pkg::CODE_LAST_USABLE
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	// Program memory
	output logic      [15:0] code_addr,
	input  wire logic [15:0] code_rdata,
	output logic             code_we,
	output logic      [15:0] code_waddr,
	output logic      [7:0]  code_wdata,
	// Data RAM and external SFR space
	output logic      [7:0]  data_addr,
	output logic             data_sfr,
	output logic             data_we,
	output logic      [7:0]  data_wdata,
	input  wire logic [7:0]  ram_rdata,
	input  wire logic [7:0]  sfr_rdata,
	// Status
	output logic             retired
);

	if (CODE_LIMIT > cpu_pkg::CODE_TOP) begin : g_bad_limit
		$error("CODE_LIMIT beyond implemented program memory");
	end

	////////////////////////////////////////////////////////////////////
	typedef struct packed {
		cpu_pkg::state_e st;
		logic [2:0]      cyc;
		logic [7:0]      op;
		logic [7:0]      b1;
		logic [7:0]      b2;
		logic [15:0]     pc;
		logic [15:0]     tgt;
		logic            taken;
		logic [7:0]      stack_pointer;
		logic [7:0]      status_word;
		logic [7:0]      accum;
		logic [7:0]      ptr_lo;
		logic [7:0]      ptr_hi;
		logic [7:0]      store_ctrl;
		logic [15:0]     code_addr;
		logic            code_we;
		logic [15:0]     code_waddr;
		logic [7:0]      code_wdata;
		logic [7:0]      data_addr;
		logic            data_sfr;
		logic            data_we;
		logic [7:0]      data_wdata;
		logic            retired;
	} core_s;

	core_s s_q;
	core_s s_d;

	////////////////////////////////////////////////////////////////////
	function automatic cpu_pkg::op_e decode(input logic [7:0] o);
		casez (o)
			8'h00, 8'ha5:                   return cpu_pkg::OP_NOP;
			8'hc3, 8'hd3, 8'hb3:            return cpu_pkg::OP_CARRY;
			8'hc2, 8'hd2, 8'hb2, 8'h82, 8'hb0,
			8'h72, 8'ha0, 8'ha2, 8'h92:     return cpu_pkg::OP_BIT;
			8'h40, 8'h50, 8'h60, 8'h70:     return cpu_pkg::OP_JCOND;
			8'h10, 8'h20, 8'h30:            return cpu_pkg::OP_JBIT;
			8'h12:                          return cpu_pkg::OP_LONG_CALL;
			8'h22, 8'h32:                   return cpu_pkg::OP_RETURN;
			8'h02:                          return cpu_pkg::OP_LONG_JUMP;
			8'h80:                          return cpu_pkg::OP_SHORT_JUMP;
			8'h73:                          return cpu_pkg::OP_JUMP_INDEXED;
			8'hb4:                          return cpu_pkg::OP_CMP_IMM;
			8'hb5:                          return cpu_pkg::OP_CMP_DIR;
			8'hb6, 8'hb7:                   return cpu_pkg::OP_CMP_IND;
			8'b1011_1???:                   return cpu_pkg::OP_CMP_REG;
			8'b1101_1???:                   return cpu_pkg::OP_DEC_REG;
			8'hd5:                          return cpu_pkg::OP_DEC_DIR;
			8'hc0:                          return cpu_pkg::OP_PUSH;
			8'hd0:                          return cpu_pkg::OP_POP;
			8'hf0:                          return cpu_pkg::OP_EXT_PTR;
			8'hf2, 8'hf3:                   return cpu_pkg::OP_EXT_IDX;
			8'b???1_0001:                   return cpu_pkg::OP_PAGE_CALL;
			8'b???0_0001:                   return cpu_pkg::OP_PAGE_JUMP;
			// Opcodes outside this core's set retire as NOP
			default:                        return cpu_pkg::OP_NOP;
		endcase
	endfunction

	function automatic logic [15:0] len_of(input cpu_pkg::op_e c);
		unique case (c)
			cpu_pkg::OP_NOP, cpu_pkg::OP_CARRY, cpu_pkg::OP_RETURN,
			cpu_pkg::OP_JUMP_INDEXED, cpu_pkg::OP_EXT_PTR,
			cpu_pkg::OP_EXT_IDX:
				return cpu_pkg::INSTR_LEN1;
			cpu_pkg::OP_JBIT, cpu_pkg::OP_LONG_CALL, cpu_pkg::OP_LONG_JUMP,
			cpu_pkg::OP_CMP_IMM, cpu_pkg::OP_CMP_DIR, cpu_pkg::OP_CMP_REG,
			cpu_pkg::OP_CMP_IND, cpu_pkg::OP_DEC_DIR:
				return cpu_pkg::INSTR_LEN3;
			default:
				return cpu_pkg::INSTR_LEN2;
		endcase
	endfunction

	function automatic logic [2:0] cyc_of(input cpu_pkg::op_e c,
	                                      input logic        tk);
		logic [2:0] extra;
		extra = tk ? cpu_pkg::CYC_TAKEN_EXTRA : 3'h0;
		unique case (c)
			cpu_pkg::OP_NOP, cpu_pkg::OP_CARRY:
				return cpu_pkg::CYC_SINGLE;
			cpu_pkg::OP_BIT:
				return cpu_pkg::CYC_BIT_OP;
			cpu_pkg::OP_JCOND, cpu_pkg::OP_DEC_REG:
				return cpu_pkg::CYC_COND_SHORT + extra;
			cpu_pkg::OP_JBIT, cpu_pkg::OP_CMP_IMM, cpu_pkg::OP_CMP_DIR,
			cpu_pkg::OP_CMP_REG, cpu_pkg::OP_DEC_DIR:
				return cpu_pkg::CYC_COND_LONG + extra;
			cpu_pkg::OP_CMP_IND:
				return cpu_pkg::CYC_CMP_IND + extra;
			cpu_pkg::OP_PAGE_CALL, cpu_pkg::OP_PAGE_JUMP,
			cpu_pkg::OP_SHORT_JUMP, cpu_pkg::OP_JUMP_INDEXED:
				return cpu_pkg::CYC_PAGE;
			cpu_pkg::OP_LONG_CALL, cpu_pkg::OP_LONG_JUMP:
				return cpu_pkg::CYC_LONG;
			cpu_pkg::OP_RETURN:
				return cpu_pkg::CYC_RETURN;
			cpu_pkg::OP_PUSH, cpu_pkg::OP_POP:
				return cpu_pkg::CYC_STACK;
			default:
				return cpu_pkg::CYC_EXT_MOVE;
		endcase
	endfunction

	function automatic logic [15:0] rel_target(input logic [15:0] base,
	                                           input logic [7:0]  off);
		return base + {{8{off[7]}}, off};
	endfunction

	// SFR bits live in bytes ending 0 or 8
	function automatic logic [7:0] bit_byte(input logic [7:0] b);
		return b[7] ? {b[7:3], 3'h0}
		            : (cpu_pkg::BIT_RAM_BASE | {4'h0, b[6:3]});
	endfunction

	function automatic logic [7:0] bank_addr(input logic [7:0] sw,
	                                         input logic [2:0] n);
		return {3'h0, sw[cpu_pkg::BANK_SELECT_HIGH_BIT],
		        sw[cpu_pkg::BANK_SELECT_LOW_BIT], n};
	endfunction

	////////////////////////////////////////////////////////////////////
	cpu_pkg::op_e cls;
	logic [7:0]   opc;
	logic [7:0]   b1;
	logic [2:0]   k;
	logic [15:0]  nxt;
	logic [7:0]   rv;
	logic         bitv;
	logic [7:0]   mask;
	logic         tk;
	logic [15:0]  tgt;
	logic         rd_req;
	logic         rd_sfr;
	logic [7:0]   rd_addr;
	logic         wr_req;
	logic         wr_sfr;
	logic [7:0]   wr_addr;
	logic [7:0]   wr_val;
	logic         store_ok;
	logic [7:0]   lhs;
	logic [7:0]   rhs;

	always_comb begin
		s_d      = s_q;
		s_d.retired = 1'b0;
		s_d.code_we = 1'b0;
		s_d.data_we = 1'b0;
		opc      = (s_q.st == cpu_pkg::ST_FETCH) ? code_rdata[7:0] : s_q.op;
		b1       = (s_q.st == cpu_pkg::ST_FETCH) ? code_rdata[15:8] : s_q.b1;
		cls      = decode(opc);
		k        = s_q.cyc;
		nxt      = s_q.pc + len_of(cls);
		tk       = (s_q.st == cpu_pkg::ST_FETCH) ? 1'b0 : s_q.taken;
		tgt      = s_q.tgt;
		rd_req   = 1'b0;
		rd_sfr   = 1'b0;
		rd_addr  = 8'h00;
		wr_req   = 1'b0;
		wr_sfr   = 1'b0;
		wr_addr  = 8'h00;
		wr_val   = 8'h00;
		lhs      = 8'h00;
		rhs      = 8'h00;
		// Read data for the address issued last cycle
		rv = ram_rdata;
		if (s_q.data_sfr) begin
			unique case (s_q.data_addr)
				cpu_pkg::STACK_POINTER_ADDR:   rv = s_q.stack_pointer;
				cpu_pkg::DATA_PTR_LO_ADDR:     rv = s_q.ptr_lo;
				cpu_pkg::DATA_PTR_HI_ADDR:     rv = s_q.ptr_hi;
				cpu_pkg::PROG_STORE_CTRL_ADDR: rv = s_q.store_ctrl;
				cpu_pkg::STATUS_WORD_ADDR:     rv = s_q.status_word;
				cpu_pkg::ACCUM_ADDR:           rv = s_q.accum;
				default:                       rv = sfr_rdata;
			endcase
		end
		bitv     = rv[s_q.b1[2:0]];
		mask     = 8'h01 << s_q.b1[2:0];
		store_ok = s_q.store_ctrl[cpu_pkg::STORE_WRITE_EN_BIT];
		if (s_q.st == cpu_pkg::ST_FETCH) begin
			s_d.op        = opc;
			s_d.b1        = b1;
			s_d.code_addr = s_q.pc + cpu_pkg::INSTR_LEN2;
		end else if (k == 3'h1) begin
			s_d.b2 = code_rdata[7:0];
		end

		unique case (cls)
			cpu_pkg::OP_CARRY: begin
				s_d.status_word[cpu_pkg::STATUS_CARRY_BIT] =
					(opc == 8'hd3) | ((opc == 8'hb3) &
					~s_q.status_word[cpu_pkg::STATUS_CARRY_BIT]);
			end
			cpu_pkg::OP_BIT, cpu_pkg::OP_JBIT: begin
				if (k == 3'h0) begin
					rd_req  = 1'b1;
					rd_sfr  = b1[7];
					rd_addr = bit_byte(b1);
				end else if (cls == cpu_pkg::OP_JBIT) begin
					// Decide once: the cleared bit must not undo the branch
					if (k == 3'h1) begin
						tk  = (opc == 8'h30) ? ~bitv : bitv;
						tgt = rel_target(nxt, code_rdata[7:0]);
						if (opc == 8'h10 && bitv) begin
							wr_req = 1'b1;
							wr_val = rv & ~mask;
						end
					end
				end else begin
					unique case (opc)
						8'h82: s_d.status_word[cpu_pkg::STATUS_CARRY_BIT] =
							s_q.status_word[cpu_pkg::STATUS_CARRY_BIT] & bitv;
						8'hb0: s_d.status_word[cpu_pkg::STATUS_CARRY_BIT] =
							s_q.status_word[cpu_pkg::STATUS_CARRY_BIT] & ~bitv;
						8'h72: s_d.status_word[cpu_pkg::STATUS_CARRY_BIT] =
							s_q.status_word[cpu_pkg::STATUS_CARRY_BIT] | bitv;
						8'ha0: s_d.status_word[cpu_pkg::STATUS_CARRY_BIT] =
							s_q.status_word[cpu_pkg::STATUS_CARRY_BIT] | ~bitv;
						8'ha2: s_d.status_word[cpu_pkg::STATUS_CARRY_BIT] = bitv;
						8'hc2: begin wr_req = 1'b1; wr_val = rv & ~mask; end
						8'hd2: begin wr_req = 1'b1; wr_val = rv | mask; end
						8'hb2: begin wr_req = 1'b1; wr_val = rv ^ mask; end
						default: begin
							wr_req = 1'b1;
							wr_val = s_q.status_word[cpu_pkg::STATUS_CARRY_BIT]
								? (rv | mask) : (rv & ~mask);
						end
					endcase
				end
				wr_sfr  = s_q.b1[7];
				wr_addr = bit_byte(s_q.b1);
			end
			cpu_pkg::OP_JCOND: begin
				unique case (opc)
					8'h40:   tk = s_q.status_word[cpu_pkg::STATUS_CARRY_BIT];
					8'h50:   tk = ~s_q.status_word[cpu_pkg::STATUS_CARRY_BIT];
					8'h60:   tk = (s_q.accum == 8'h00);
					default: tk = (s_q.accum != 8'h00);
				endcase
				tgt = rel_target(nxt, b1);
			end
			cpu_pkg::OP_PAGE_CALL, cpu_pkg::OP_LONG_CALL: begin
				if (k < 3'h2) begin
					// Increment first, then store: pointer marks last used
					wr_req  = 1'b1;
					wr_addr = s_q.stack_pointer + 8'h01;
					wr_val  = (k == 3'h0) ? nxt[7:0] : nxt[15:8];
					s_d.stack_pointer = s_q.stack_pointer + 8'h01;
				end
				tk = 1'b1;
				if (cls == cpu_pkg::OP_PAGE_CALL && k == 3'h0)
					tgt = {nxt[15:11], opc[7:5], b1};
				else if (cls == cpu_pkg::OP_LONG_CALL && k == 3'h1)
					tgt = {s_q.b1, code_rdata[7:0]};
			end
			cpu_pkg::OP_RETURN: begin
				if (k < 3'h2) begin
					rd_req  = 1'b1;
					rd_addr = s_q.stack_pointer;
					s_d.stack_pointer = s_q.stack_pointer - 8'h01;
				end
				if (k == 3'h1) tgt = {rv, 8'h00};
				if (k == 3'h2) begin
					tgt = {s_q.tgt[15:8], rv};
					tk  = 1'b1;
				end
			end
			cpu_pkg::OP_PAGE_JUMP: begin
				tk  = 1'b1;
				tgt = {nxt[15:11], opc[7:5], b1};
			end
			cpu_pkg::OP_LONG_JUMP: begin
				tk = 1'b1;
				if (k == 3'h1) tgt = {s_q.b1, code_rdata[7:0]};
			end
			cpu_pkg::OP_SHORT_JUMP: begin
				tk = 1'b1;
				if (k == 3'h0) tgt = rel_target(nxt, b1);
			end
			cpu_pkg::OP_JUMP_INDEXED: begin
				tk = 1'b1;
				if (k == 3'h0)
					tgt = {s_q.ptr_hi, s_q.ptr_lo} + {8'h00, s_q.accum};
			end
			cpu_pkg::OP_CMP_IMM, cpu_pkg::OP_CMP_DIR, cpu_pkg::OP_CMP_REG,
			cpu_pkg::OP_CMP_IND: begin
				if (k == 3'h0 && cls != cpu_pkg::OP_CMP_IMM) begin
					rd_req  = 1'b1;
					rd_sfr  = (cls == cpu_pkg::OP_CMP_DIR) & b1[7];
					rd_addr = (cls == cpu_pkg::OP_CMP_DIR) ? b1 :
						bank_addr(s_q.status_word, (cls == cpu_pkg::OP_CMP_REG)
						? opc[2:0] : {2'h0, opc[0]});
				end else if (k == 3'h1 && cls == cpu_pkg::OP_CMP_IND) begin
					rd_req  = 1'b1;
					rd_addr = rv;
				end else if (k != 3'h0 || cls == cpu_pkg::OP_CMP_IMM) begin
					if ((k == 3'h1) ^ (cls == cpu_pkg::OP_CMP_IND)) begin
						lhs = (cls == cpu_pkg::OP_CMP_DIR ||
						       cls == cpu_pkg::OP_CMP_IMM) ? s_q.accum : rv;
						rhs = (cls == cpu_pkg::OP_CMP_DIR) ? rv : s_q.b1;
						tk  = (lhs != rhs);
						s_d.status_word[cpu_pkg::STATUS_CARRY_BIT] = lhs < rhs;
						tgt = rel_target(nxt, (cls == cpu_pkg::OP_CMP_IND)
							? s_q.b2 : code_rdata[7:0]);
					end
				end
			end
			cpu_pkg::OP_DEC_REG, cpu_pkg::OP_DEC_DIR: begin
				if (k == 3'h0) begin
					rd_req  = 1'b1;
					rd_sfr  = (cls == cpu_pkg::OP_DEC_DIR) & b1[7];
					rd_addr = (cls == cpu_pkg::OP_DEC_DIR) ? b1
						: bank_addr(s_q.status_word, opc[2:0]);
				end else if (k == 3'h1) begin
					// One write only; an absorbed register would count twice
					wr_req  = 1'b1;
					wr_sfr  = s_q.data_sfr;
					wr_addr = s_q.data_addr;
					wr_val  = rv - 8'h01;
					tk      = (wr_val != 8'h00);
					tgt     = rel_target(nxt, (cls == cpu_pkg::OP_DEC_REG)
						? s_q.b1 : code_rdata[7:0]);
				end
			end
			cpu_pkg::OP_PUSH: begin
				if (k == 3'h0) begin
					rd_req  = 1'b1;
					rd_sfr  = b1[7];
					rd_addr = b1;
				end else if (k == 3'h1) begin
					wr_req  = 1'b1;
					wr_addr = s_q.stack_pointer + 8'h01;
					wr_val  = rv;
					s_d.stack_pointer = s_q.stack_pointer + 8'h01;
				end
			end
			cpu_pkg::OP_POP: begin
				if (k == 3'h0) begin
					rd_req  = 1'b1;
					rd_addr = s_q.stack_pointer;
					s_d.stack_pointer = s_q.stack_pointer - 8'h01;
				end else if (k == 3'h1) begin
					wr_req  = 1'b1;
					wr_sfr  = s_q.b1[7];
					wr_addr = s_q.b1;
					wr_val  = rv;
				end
			end
			cpu_pkg::OP_EXT_PTR, cpu_pkg::OP_EXT_IDX: begin
				if (k == 3'h0 && cls == cpu_pkg::OP_EXT_IDX) begin
					rd_req  = 1'b1;
					rd_addr = bank_addr(s_q.status_word, {2'h0, opc[0]});
				end else if (k == {2'h0, cls == cpu_pkg::OP_EXT_IDX}) begin
					s_d.code_waddr = (cls == cpu_pkg::OP_EXT_PTR)
						? {s_q.ptr_hi, s_q.ptr_lo} : {8'h00, rv};
					s_d.code_wdata = s_q.accum;
					// Without the enable the write goes nowhere here
					s_d.code_we = store_ok &&
						(s_d.code_waddr <= CODE_LIMIT);
				end
			end
			default: ;
		endcase

		s_d.taken = tk;
		s_d.tgt   = tgt;
		if (k == cyc_of(cls, tk) - 3'h1) begin
			s_d.pc        = tk ? tgt : nxt;
			s_d.code_addr = s_d.pc;
			s_d.cyc       = 3'h0;
			s_d.st        = cpu_pkg::ST_FETCH;
			s_d.retired   = 1'b1;
		end else begin
			s_d.cyc = k + 3'h1;
			s_d.st  = cpu_pkg::ST_EXEC;
		end

		if (wr_req && wr_sfr) begin
			unique case (wr_addr)
				cpu_pkg::STACK_POINTER_ADDR:   s_d.stack_pointer = wr_val;
				cpu_pkg::DATA_PTR_LO_ADDR:     s_d.ptr_lo = wr_val;
				cpu_pkg::DATA_PTR_HI_ADDR:     s_d.ptr_hi = wr_val;
				cpu_pkg::PROG_STORE_CTRL_ADDR: s_d.store_ctrl = wr_val;
				cpu_pkg::STATUS_WORD_ADDR:     s_d.status_word = wr_val;
				cpu_pkg::ACCUM_ADDR:           s_d.accum = wr_val;
				default:                       s_d.data_we = 1'b1;
			endcase
		end else if (wr_req) begin
			s_d.data_we = 1'b1;
		end
		if (wr_req) begin
			s_d.data_addr  = wr_addr;
			s_d.data_sfr   = wr_sfr;
			s_d.data_wdata = wr_val;
		end else if (rd_req) begin
			s_d.data_addr  = rd_addr;
			s_d.data_sfr   = rd_sfr;
		end
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q               <= '0;
			s_q.pc            <= cpu_pkg::PC_RESET;
			s_q.code_addr     <= cpu_pkg::PC_RESET;
			s_q.stack_pointer <= cpu_pkg::STACK_POINTER_RESET;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	assign code_addr  = s_q.code_addr;
	assign code_we    = s_q.code_we;
	assign code_waddr = s_q.code_waddr;
	assign code_wdata = s_q.code_wdata;
	assign data_addr  = s_q.data_addr;
	assign data_sfr   = s_q.data_sfr;
	assign data_we    = s_q.data_we;
	assign data_wdata = s_q.data_wdata;
	assign retired    = s_q.retired;

endmodule // branch_bit_core

`default_nettype wire

// >>> verilog/cpu_pkg.sv
// Shared constants of the bit and branch execution core.
// Assumes one 100 MHz clock; memories live outside the core.
`default_nettype none

package cpu_pkg;

	////////////////////////////////////////////////////////////////////
	// Internal special function registers (direct addresses)
	localparam logic [7:0]  STACK_POINTER_ADDR   = 8'h81;
	localparam logic [7:0]  DATA_PTR_LO_ADDR     = 8'h82;
	localparam logic [7:0]  DATA_PTR_HI_ADDR     = 8'h83;
	localparam logic [7:0]  PROG_STORE_CTRL_ADDR = 8'h8f;
	localparam logic [7:0]  STATUS_WORD_ADDR     = 8'hd0;
	localparam logic [7:0]  ACCUM_ADDR           = 8'he0;

	////////////////////////////////////////////////////////////////////
	// Field positions and reset values
	localparam int          STATUS_CARRY_BIT     = 7;
	localparam int          BANK_SELECT_LOW_BIT  = 3;
	localparam int          BANK_SELECT_HIGH_BIT = 4;
	localparam int          STORE_WRITE_EN_BIT   = 0;
	localparam logic [7:0]  STACK_POINTER_RESET  = 8'h07;
	localparam logic [15:0] PC_RESET             = 16'h0000;
	localparam logic [7:0]  BIT_RAM_BASE         = 8'h20;
	localparam logic [15:0] CODE_LAST_USABLE     = 16'h3dff;
	localparam logic [15:0] CODE_TOP             = 16'h3fff;

	////////////////////////////////////////////////////////////////////
	// Instruction lengths and cycle counts
	localparam logic [15:0] INSTR_LEN1           = 16'h0001;
	localparam logic [15:0] INSTR_LEN2           = 16'h0002;
	localparam logic [15:0] INSTR_LEN3           = 16'h0003;
	localparam logic [2:0]  CYC_SINGLE           = 3'h1;
	localparam logic [2:0]  CYC_BIT_OP           = 3'h2;
	localparam logic [2:0]  CYC_COND_SHORT       = 3'h2;
	localparam logic [2:0]  CYC_COND_LONG        = 3'h3;
	localparam logic [2:0]  CYC_CMP_IND          = 3'h4;
	localparam logic [2:0]  CYC_PAGE             = 3'h3;
	localparam logic [2:0]  CYC_LONG             = 3'h4;
	localparam logic [2:0]  CYC_RETURN           = 3'h5;
	localparam logic [2:0]  CYC_STACK            = 3'h3;
	localparam logic [2:0]  CYC_EXT_MOVE         = 3'h3;
	localparam logic [2:0]  CYC_TAKEN_EXTRA      = 3'h1;

	////////////////////////////////////////////////////////////////////
	// Instruction classes and sequencer states
	typedef enum logic [4:0] {
		OP_NOP, OP_CARRY, OP_BIT, OP_JCOND, OP_JBIT,
		OP_PAGE_CALL, OP_LONG_CALL, OP_RETURN, OP_PAGE_JUMP,
		OP_LONG_JUMP, OP_SHORT_JUMP, OP_JUMP_INDEXED,
		OP_CMP_IMM, OP_CMP_DIR, OP_CMP_REG, OP_CMP_IND,
		OP_DEC_REG, OP_DEC_DIR, OP_PUSH, OP_POP,
		OP_EXT_PTR, OP_EXT_IDX
	} op_e;

	typedef enum logic {ST_FETCH, ST_EXEC} state_e;

endpackage : cpu_pkg

`default_nettype wire

// >>> sim/branch_bit_core_chk.sv
// Port checker for the bit and branch execution core.
// Assumes it is bound onto branch_bit_core and sees its ports only.
`default_nettype none

module branch_bit_core_chk #(
	parameter logic [15:0] CODE_LIMIT = 16'h3dff
) (
	// Clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        clk_en,
	// Program memory
	input wire logic [15:0] code_addr,
	input wire logic [15:0] code_rdata,
	input wire logic        code_we,
	input wire logic [15:0] code_waddr,
	input wire logic [7:0]  code_wdata,
	// Data space
	input wire logic [7:0]  data_addr,
	input wire logic        data_sfr,
	input wire logic        data_we,
	input wire logic [7:0]  data_wdata,
	input wire logic [7:0]  ram_rdata,
	input wire logic [7:0]  sfr_rdata,
	// Status
	input wire logic        retired
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	////////////////////////////////////////////////////////////////////
	code_pulse_a:
	assert property (code_we && clk_en |=> !code_we)
		else $error("program store write longer than one cycle");
	code_limit_a:
	assert property (code_we |-> code_waddr <= CODE_LIMIT)
		else $error("program store write above usable range");
	sfr_direct_a:
	assert property (data_we && data_sfr |-> data_addr[7])
		else $error("register space write below its range");
	absorb_sfr_a:
	assert property (data_we && data_sfr |-> data_addr != 8'h81)
		else $error("stack pointer write left the core");
	start_addr_a:
	assert property ($rose(resetn) |-> code_addr == 16'h0000 && !data_we)
		else $error("fetch after reset not at zero");
	// Calls push two bytes back to back; each lands one above the last
	push_step_a:
	assert property (retired && clk_en && (code_rdata[7:0] == 8'h12 ||
		code_rdata[4:0] == 5'h11) ##1 clk_en |-> data_we && !data_sfr
		##1 data_we && !data_sfr && data_addr == $past(data_addr) + 8'h01)
		else $error("stack push not at incremented pointer");
	spare_nop_a:
	assert property (retired && clk_en && code_rdata[7:0] == 8'ha5
		|=> retired && code_addr == $past(code_addr) + 16'h0001)
		else $error("spare opcode not a one cycle no-op");
	short_loop_a:
	assert property (retired && code_rdata == 16'hfe80 ##0 clk_en [*4]
		|-> retired && code_addr == $past(code_addr, 3))
		else $error("short jump to itself not three cycles");

	cover property (retired && code_rdata[7:0] == 8'h22);
	cover property (data_we && !data_sfr ##1 data_we);
	cover property (code_we);
endmodule // branch_bit_core_chk

bind branch_bit_core branch_bit_core_chk #(.CODE_LIMIT(CODE_LIMIT)) chk_u (
	.clk(clk), .resetn(resetn), .clk_en(clk_en), .code_addr(code_addr),
	.code_rdata(code_rdata), .code_we(code_we), .code_waddr(code_waddr),
	.code_wdata(code_wdata), .data_addr(data_addr), .data_sfr(data_sfr),
	.data_we(data_we), .data_wdata(data_wdata), .ram_rdata(ram_rdata),
	.sfr_rdata(sfr_rdata), .retired(retired));

`default_nettype wire

// >>> sim/core_mem_model.sv
// Program memory, data RAM and register space facing the core.
// Assumes the bench loads the arrays before reset is released.
`default_nettype none

module core_mem_model (
	// Clock
	input  wire logic        clk,
	// Program memory
	input  wire logic [15:0] code_addr,
	output logic      [15:0] code_rdata,
	input  wire logic        code_we,
	input  wire logic [15:0] code_waddr,
	input  wire logic [7:0]  code_wdata,
	// Data space
	input  wire logic [7:0]  data_addr,
	input  wire logic        data_sfr,
	input  wire logic        data_we,
	input  wire logic [7:0]  data_wdata,
	output logic      [7:0]  ram_rdata,
	output logic      [7:0]  sfr_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] code [0:65535];
	logic [7:0] ram  [0:255];
	logic [7:0] sfr  [0:255];

	assign code_rdata = {code[code_addr + 16'h0001], code[code_addr]};
	// Upper RAM and register space share addresses, never storage
	assign ram_rdata = ram[data_addr];
	assign sfr_rdata = sfr[data_addr];

	always @(posedge clk) begin
		if (code_we)
			code[code_waddr] <= code_wdata;
		if (data_we && data_sfr)
			sfr[data_addr] <= data_wdata;
		if (data_we && !data_sfr)
			ram[data_addr] <= data_wdata;
	end
endmodule // core_mem_model

`default_nettype wire

// >>> sim/tb_branch_bit_core.sv
// Bench for the bit and branch core: runs a fixed program and times it.
// Assumes the memory model answers in the same cycle.
`default_nettype none

module tb_branch_bit_core;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, resetn, clk_en, code_we, data_sfr, data_we, retired;
	logic [15:0] code_addr, code_rdata, code_waddr, hold;
	logic [7:0]  code_wdata, data_addr, data_wdata, ram_rdata, sfr_rdata;
	int          fail_count, compares, n, nwr;
	// Next start address and cycle count of each retired instruction
	localparam logic [19:0] ROWS [30] = '{
		20'h00011, 20'h00021, 20'h00031, 20'h00041, 20'h00051,
		20'h00072, 20'h000b3, 20'h000e3, 20'h00102, 20'h00154,
		20'h001a4, 20'h001d3, 20'h001d3, 20'h001f2, 20'h00244,
		20'h00274, 20'h00404, 20'h01004, 20'h00435, 20'h00803,
		20'h00455, 20'h01203, 20'h01223, 20'h01243, 20'h01253,
		20'h01273, 20'h01293, 20'h012a3, 20'h012a3, 20'h012a3};

	branch_bit_core dut_u (.clk(clk), .resetn(resetn), .clk_en(clk_en),
		.code_addr(code_addr), .code_rdata(code_rdata), .code_we(code_we),
		.code_waddr(code_waddr), .code_wdata(code_wdata),
		.data_addr(data_addr), .data_sfr(data_sfr), .data_we(data_we),
		.data_wdata(data_wdata), .ram_rdata(ram_rdata),
		.sfr_rdata(sfr_rdata), .retired(retired));
	core_mem_model mem_u (.clk(clk), .code_addr(code_addr),
		.code_rdata(code_rdata), .code_we(code_we), .code_waddr(code_waddr),
		.code_wdata(code_wdata), .data_addr(data_addr), .data_sfr(data_sfr),
		.data_we(data_we), .data_wdata(data_wdata), .ram_rdata(ram_rdata),
		.sfr_rdata(sfr_rdata));

	////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s exp %h seen %h", what, exp, seen);
		end
	endtask

	task automatic ld(input logic [15:0] a, input logic [127:0] b,
		input int len);
		for (int i = 0; i < len; i++)
			mem_u.code[a + 16'(i)] = b[8*(len-1-i) +: 8];
	endtask

	task automatic results();
		if (fail_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
		if (code_we === 1'b1 && clk_en)
			nwr++;

	initial begin
		repeat (3000) @(posedge clk);
		fail_count++;
		results();
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		fail_count = 0;
		compares = 0;
		nwr = 0;
		resetn = 1'b0;
		clk_en = 1'b1;
		for (int i = 0; i < 512; i++)
			mem_u.code[i] = 8'h00;
		ld(16'h0000, 128'hc3d3b3a5004005500200006001007005, 16);
		ld(16'h0010, 128'h20000200001000020000200002d8feb4, 16);
		ld(16'h0020, 128'h05020000b73302020040, 10);
		ld(16'h0040, 128'h12010011802120, 7);
		ld(16'h0080, 128'h32, 1);
		ld(16'h0100, 128'h22, 1);
		ld(16'h0120, 128'hc030d08ff0c031d083f080fe, 12);
		mem_u.ram[8'h00] = 8'h02;
		mem_u.ram[8'h01] = 8'h90;
		mem_u.ram[8'h90] = 8'h33;
		mem_u.ram[8'h20] = 8'h01;
		mem_u.ram[8'h30] = 8'h01;
		mem_u.ram[8'h31] = 8'h3f;
		repeat (8) @(posedge clk);
		check("reset_pc", code_addr, 16'h0000);
		resetn <= 1'b1;
		for (int i = 0; i < 30; i++) begin
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (retired !== 1'b1 && n < 40);
			check("next_pc", code_addr, ROWS[i][19:4]);
			if (i > 0)
				check("cycles", 16'(n), {12'h000, ROWS[i][3:0]});
		end
		// Awkward cases: side effects left behind in memory
		check("bit_clear", {8'h00, mem_u.ram[8'h20]}, 16'h0000);
		check("dec_reg", {8'h00, mem_u.ram[8'h00]}, 16'h0000);
		check("stack_lo", {8'h00, mem_u.ram[8'h08]}, 16'h003f);
		check("stack_hi", {8'h00, mem_u.ram[8'h09]}, 16'h0000);
		check("store_wr", {8'h00, mem_u.code[0]}, 16'h0000);
		check("store_cnt", 16'(nwr), 16'h0001);
		@(posedge clk);
		clk_en <= 1'b0;
		@(negedge clk);
		hold = code_addr;
		repeat (3) begin
			@(negedge clk);
			check("frozen_pc", code_addr, hold);
		end
		@(posedge clk);
		clk_en <= 1'b1;
		repeat (8) @(posedge clk);
		// Reset in mid-run: restart at zero, first opcode on first edge
		resetn <= 1'b0;
		@(negedge clk);
		check("reset_again", code_addr, 16'h0000);
		check("reset_retired", {15'h0000, retired}, 16'h0000);
		@(posedge clk);
		resetn <= 1'b1;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (retired !== 1'b1 && n < 40);
		check("restart_pc", code_addr, 16'h0001);
		check("restart_wait", 16'(n), 16'h0002);
		results();
	end
endmodule // tb_branch_bit_core

`default_nettype wire
